// >>> cbc_ctrl.sv
// processor control signals at the external bus: nmi, halt, fetch and io strobes
// Operation
// R1: nonmaskable request wins over every maskable request.
// R2: nonmaskable request is accepted only at instruction completion.
// R3: no interrupt enable bit can block the nonmaskable request.
// R4: external nmi pin and watchdog_timer request merge into one request.
// R5: halt output is low while the processor is stopped by halt.
// R6: fetch strobe goes low with memory request and read on opcode fetch.
// R7: fetch strobe is undriven during reset and bus acknowledge.
// R8: io request strobe marks io accesses, read or write strobe gives direction.
// R9: io request is undriven in reset and an input during bus acknowledge.
// R10: reset source holds reset low three clocks and until clock is stable; not built here, the board is trusted to do it.
// R11: nmi pin is synchronised and latched until accepted.
`timescale 1ns/10ps
module cbc_ctrl
	import cbc_pkg::*;
(
	input  wire logic core_clk,
	input  wire logic rstn,
	input  wire logic nmi_pin_n,
	input  wire logic watchdog_timer_nmi,
	input  wire logic instr_end,
	input  wire logic irq_req,
	input  wire logic irq_en,
	input  wire logic halted,
	input  wire logic bus_ack,
	input  wire logic cpu_fetch,
	input  wire logic cpu_mem,
	input  wire logic cpu_io,
	input  wire logic cpu_rd,
	input  wire logic cpu_wr,
	input  wire logic io_request_n_in,
	output logic      nmi_take,
	output logic      irq_take,
	output logic      halt_n,
	output logic      fetch_strobe_n,
	output logic      fetch_strobe_oe,
	output logic      memory_request_n,
	output logic      rd_n,
	output logic      wr_n,
	output logic      io_request_n,
	output logic      io_request_oe,
	output logic      io_request_ext_n
);

	cbc_state_t s_q;
	cbc_state_t s_d;

	logic nmi_lvl_new;
	logic nmi_event;
	logic nmi_want;
	logic accept_nmi;
	logic own_bus;

	always_comb begin
		s_d = s_q;

		// pin passes three flops; a change only counts once the last two agree
		s_d.nmi_sync = {s_q.nmi_sync[CBC_SYNC_LEN-2:0], nmi_pin_n}; // see R11
		s_d.io_sync  = {s_q.io_sync[CBC_SYNC_LEN-2:0], io_request_n_in};
		if (s_q.nmi_sync[CBC_SYNC_LEN-1] == s_q.nmi_sync[CBC_SYNC_LEN-2]) begin
			nmi_lvl_new = s_q.nmi_sync[CBC_SYNC_LEN-1];
		end else begin
			nmi_lvl_new = s_q.nmi_lvl;
		end
		s_d.nmi_lvl = nmi_lvl_new;

		// the pin is edge sensitive so a held-low pin is serviced only once
		nmi_event = (s_q.nmi_lvl & ~nmi_lvl_new) | watchdog_timer_nmi; // see R4
		nmi_want  = s_q.nmi_pend | nmi_event;

		// irq_en is deliberately absent from the acceptance term
		accept_nmi = instr_end & nmi_want; // see R2 see R3
		s_d.nmi_take = accept_nmi;

		// an event in the accepting cycle is folded into that acceptance, not lost
		s_d.nmi_pend = nmi_want & ~accept_nmi; // see R11

		s_d.irq_take = instr_end & irq_req & irq_en & ~nmi_want; // see R1

		s_d.halt_n = ~halted; // see R5

		// bus ownership: released on the first clock out of reset if bus_ack is high, as from the own state
		case (s_q.bus_st)
			CBC_ST_RESET: begin
				s_d.bus_st = bus_ack ? CBC_ST_ACK : CBC_ST_OWN;
			end
			CBC_ST_OWN: begin
				s_d.bus_st = bus_ack ? CBC_ST_ACK : CBC_ST_OWN;
			end
			CBC_ST_ACK: begin
				s_d.bus_st = bus_ack ? CBC_ST_ACK : CBC_ST_OWN;
			end
			default: begin
				s_d.bus_st = CBC_ST_RESET;
			end
		endcase
		own_bus = (s_d.bus_st == CBC_ST_OWN);

		s_d.fetch_oe = own_bus; // see R7
		s_d.io_oe    = own_bus; // see R9

		if (own_bus) begin
			s_d.fetch_n = ~cpu_fetch; // see R6
			s_d.memory_request_n_n  = ~(cpu_fetch | cpu_mem); // see R6
			s_d.rd_n    = ~(cpu_fetch | cpu_rd); // see R6
			s_d.wr_n    = ~(cpu_wr & ~cpu_fetch);
			s_d.io_n    = ~(cpu_io & ~cpu_fetch); // see R8
		end else begin
			s_d.fetch_n = CBC_STROBE_IDLE;
			s_d.memory_request_n_n  = CBC_STROBE_IDLE;
			s_d.rd_n    = CBC_STROBE_IDLE;
			s_d.wr_n    = CBC_STROBE_IDLE;
			s_d.io_n    = CBC_STROBE_IDLE;
		end

		// during bus acknowledge the foreign master's io request is sensed
		if (s_q.bus_st == CBC_ST_ACK) begin
			if (s_q.io_sync[CBC_SYNC_LEN-1] == s_q.io_sync[CBC_SYNC_LEN-2]) begin
				s_d.io_ext_n = s_q.io_sync[CBC_SYNC_LEN-1]; // see R9
			end
		end else begin
			s_d.io_ext_n = CBC_STROBE_IDLE;
		end
	end

	// reset length is trusted to the board; no stretcher is built here (see R10)
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			s_q <= CBC_STATE_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign nmi_take         = s_q.nmi_take;
	assign irq_take         = s_q.irq_take;
	assign halt_n           = s_q.halt_n;
	assign fetch_strobe_n   = s_q.fetch_n;
	assign fetch_strobe_oe  = s_q.fetch_oe;
	assign memory_request_n = s_q.memory_request_n_n;
	assign rd_n             = s_q.rd_n;
	assign wr_n             = s_q.wr_n;
	assign io_request_n     = s_q.io_n;
	assign io_request_oe    = s_q.io_oe;
	assign io_request_ext_n = s_q.io_ext_n;

	default clocking cb_main @(posedge core_clk);
	endclocking
	default disable iff (!rstn);

	property p_nmi_over_irq; // see R1
		!(nmi_take && irq_take);
	endproperty
	a_nmi_over_irq: assert property (p_nmi_over_irq) // see R1
		else $error("maskable and nonmaskable accepted together");

	property p_nmi_at_end; // see R2
		nmi_take |-> $past(instr_end);
	endproperty
	a_nmi_at_end: assert property (p_nmi_at_end) // see R2
		else $error("nonmaskable accepted outside instruction end");

	property p_nmi_unmasked; // see R3
		(s_q.nmi_pend && instr_end && !irq_en) |=> nmi_take;
	endproperty
	a_nmi_unmasked: assert property (p_nmi_unmasked) // see R3
		else $error("pending nonmaskable blocked by enable");

	property p_wdt_merge; // see R4
		watchdog_timer_nmi |=> (s_q.nmi_pend || nmi_take);
	endproperty
	a_wdt_merge: assert property (p_wdt_merge) // see R4
		else $error("watchdog request not merged");

	property p_halt; // see R5
		##1 (halt_n == !$past(halted));
	endproperty
	a_halt: assert property (p_halt) // see R5
		else $error("halt output does not follow halted state");

	property p_fetch; // see R6
		(cpu_fetch && !bus_ack && s_q.bus_st != CBC_ST_RESET)
			|=> (!fetch_strobe_n && !memory_request_n && !rd_n && fetch_strobe_oe);
	endproperty
	a_fetch: assert property (p_fetch) // see R6
		else $error("fetch strobes not asserted together");

	property p_fetch_float; // see R7
		bus_ack |=> (!fetch_strobe_oe && fetch_strobe_n);
	endproperty
	a_fetch_float: assert property (p_fetch_float) // see R7
		else $error("fetch strobe driven while not owning the bus");

	property p_io_write; // see R8
		(cpu_io && cpu_wr && !cpu_fetch && !bus_ack && s_q.bus_st != CBC_ST_RESET)
			|=> (!io_request_n && !wr_n && rd_n && io_request_oe);
	endproperty
	a_io_write: assert property (p_io_write) // see R8
		else $error("io write strobes wrong");

	// io request must stay idle for memory cycles, fetches and foreign ownership
	property p_io_idle; // see R8
		(!cpu_io || cpu_fetch || bus_ack) |=> io_request_n;
	endproperty
	a_io_idle: assert property (p_io_idle) // see R8
		else $error("io request strobe outside io access");

	property p_io_input; // see R9
		bus_ack |=> !io_request_oe ##1 (bus_ack ? !io_request_oe : 1'b1);
	endproperty
	a_io_input: assert property (p_io_input) // see R9
		else $error("io request driven during bus acknowledge");

	property p_nmi_latch; // see R11
		$fell(s_q.nmi_lvl) |-> (s_q.nmi_pend || nmi_take);
	endproperty
	a_nmi_latch: assert property (p_nmi_latch) // see R11
		else $error("nmi pin edge not latched");

	property p_nmi_hold; // see R11
		(s_q.nmi_pend && !instr_end) |=> s_q.nmi_pend;
	endproperty
	a_nmi_hold: assert property (p_nmi_hold) // see R11
		else $error("pending nonmaskable lost before acceptance");

endmodule : cbc_ctrl

// >>> cbc_far_model.sv
// far side model: nmi source and a foreign master on the io request wire
`timescale 1ns/10ps
module cbc_far_model (
	input  wire logic core_clk,
	input  wire logic nmi_go,
	input  wire logic bus_ack,
	input  wire logic ext_io_n,
	input  wire logic io_request_n,
	input  wire logic io_request_oe,
	output logic      nmi_pin_n,
	output logic      io_request_n_in
);
	logic [2:0] cnt_q = 3'h0;
	// low for four clocks, just past the three-flop filter
	always @(posedge core_clk) cnt_q <= nmi_go ? 3'h4 : cnt_q - 3'(cnt_q != 3'h0);
	assign nmi_pin_n = (cnt_q == 3'h0);
	// pulled up; the foreign master drives it only while granted
	assign io_request_n_in = io_request_oe ? io_request_n : (bus_ack ? ext_io_n : 1'h1);
endmodule : cbc_far_model

// >>> cbc_pkg.sv
// constants and types shared by the bus control logic
package cbc_pkg;

	localparam int unsigned CBC_CLK_PERIOD_PS = 25000;
	localparam int unsigned CBC_RESET_MIN_CLK = 3;
	localparam int unsigned CBC_SYNC_LEN      = 3;

	// reset values of the pin drivers: strobes idle high, enables off
	localparam logic CBC_STROBE_IDLE = 1'h1;
	localparam logic CBC_OE_OFF      = 1'h0;
	localparam logic CBC_NMI_IDLE    = 1'h1;

	typedef enum logic [2:0] {
		CBC_ST_RESET = 3'h1,
		CBC_ST_OWN   = 3'h2,
		CBC_ST_ACK   = 3'h4
	} cbc_bus_st_t;

	typedef struct packed {
		cbc_bus_st_t                bus_st;
		logic [CBC_SYNC_LEN-1:0]    nmi_sync;
		logic [CBC_SYNC_LEN-1:0]    io_sync;
		logic                       nmi_lvl;
		logic                       nmi_pend;
		logic                       nmi_take;
		logic                       irq_take;
		logic                       halt_n;
		logic                       fetch_n;
		logic                       fetch_oe;
		logic                       memory_request_n_n;
		logic                       rd_n;
		logic                       wr_n;
		logic                       io_n;
		logic                       io_oe;
		logic                       io_ext_n;
	} cbc_state_t;

	localparam cbc_state_t CBC_STATE_RST = '{
		bus_st:   CBC_ST_RESET,
		nmi_sync: {CBC_SYNC_LEN{CBC_NMI_IDLE}},
		io_sync:  {CBC_SYNC_LEN{CBC_STROBE_IDLE}},
		nmi_lvl:  CBC_NMI_IDLE,
		nmi_pend: 1'h0,
		nmi_take: 1'h0,
		irq_take: 1'h0,
		halt_n:   CBC_STROBE_IDLE,
		fetch_n:  CBC_STROBE_IDLE,
		fetch_oe: CBC_OE_OFF,
		memory_request_n_n:   CBC_STROBE_IDLE,
		rd_n:     CBC_STROBE_IDLE,
		wr_n:     CBC_STROBE_IDLE,
		io_n:     CBC_STROBE_IDLE,
		io_oe:    CBC_OE_OFF,
		io_ext_n: CBC_STROBE_IDLE
	};

endpackage : cbc_pkg

// >>> test_cbc_ctrl.sv
// random and corner tests of the bus control logic
`timescale 1ns/10ps
module test_cbc_ctrl;
	import cbc_pkg::*;
	logic core_clk, rstn, nmi_go, ext_io_n, nmi_pin_n, watchdog_timer_nmi, instr_end;
	logic irq_req, irq_en, halted, bus_ack, cpu_fetch, cpu_mem, cpu_io, cpu_rd, cpu_wr;
	logic io_request_n_in, nmi_take, irq_take, halt_n, fetch_strobe_n, fetch_strobe_oe;
	logic memory_request_n, rd_n, wr_n, io_request_n, io_request_oe, io_request_ext_n;
	logic [5:0] v;
	int err_count, checked, cycles;
	cbc_ctrl dut_u (.core_clk, .rstn, .nmi_pin_n, .watchdog_timer_nmi, .instr_end, .irq_req,
		.irq_en, .halted, .bus_ack, .cpu_fetch, .cpu_mem, .cpu_io, .cpu_rd, .cpu_wr,
		.io_request_n_in, .nmi_take, .irq_take, .halt_n, .fetch_strobe_n, .fetch_strobe_oe,
		.memory_request_n, .rd_n, .wr_n, .io_request_n, .io_request_oe, .io_request_ext_n);
	cbc_far_model far_u (.core_clk, .nmi_go, .bus_ack, .ext_io_n, .io_request_n,
		.io_request_oe, .nmi_pin_n, .io_request_n_in);
	initial begin
		core_clk = 1'h0;
		forever #12.5 core_clk = ~core_clk;
	end
	task automatic chk(input logic got, input logic exp, input string what);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t %s got %b", $time, what, got);
		end
	endtask : chk
	task automatic step();
		@(posedge core_clk);
		@(negedge core_clk);
	endtask : step
	function automatic logic exp_irq(input logic [2:0] c);
		return !c[2] && c[1] && c[0];
	endfunction : exp_irq
	task automatic end_of_test();
		$display("errors %0d checks %0d", err_count, checked);
		if (err_count == 0 && checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : end_of_test
	// runs take well under a thousand clocks
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 3000) begin
			err_count++;
			end_of_test();
		end
	end
	initial begin
		{rstn, nmi_go, watchdog_timer_nmi, instr_end, irq_req, irq_en, halted} = 7'h0;
		{bus_ack, cpu_fetch, cpu_mem, cpu_io, cpu_rd, cpu_wr} = 6'h0;
		ext_io_n = 1'h1;
		void'($urandom(92));
		// reset held six clocks, above the three-clock minimum
		repeat (6) step();
		chk(fetch_strobe_oe | io_request_oe, 1'h0, "oe in reset");
		@(posedge core_clk) rstn <= 1'h1;
		step();
		for (int i = 0; i < 60; i++) begin
			v = 6'($urandom());
			if (v[1]) v[0] = 1'h0;
			@(posedge core_clk);
			{cpu_fetch, cpu_mem, cpu_io, cpu_rd, cpu_wr} <= v[4:0];
			halted <= v[5];
			step();
			chk(fetch_strobe_oe & io_request_oe, 1'h1, "oe");
			chk(halt_n, ~v[5], "halt");
			if (v[4]) chk(fetch_strobe_n | memory_request_n | rd_n, 1'h0, "fetch");
			else if (v[2]) begin
				chk(io_request_n, 1'h0, "io");
				chk(rd_n, ~v[1], "io rd");
				chk(wr_n, ~v[0], "io wr");
			end
		end
		@(posedge core_clk);
		{bus_ack, ext_io_n, cpu_fetch, cpu_io} <= 4'h8;
		step();
		chk(fetch_strobe_oe | io_request_oe, 1'h0, "oe in ack");
		repeat (4) step();
		chk(io_request_ext_n, 1'h0, "foreign io");
		@(posedge core_clk) {bus_ack, ext_io_n} <= 2'h1;
		// all eight mixes of watchdog, maskable request and enable
		for (int k = 0; k < 8; k++) begin
			@(posedge core_clk);
			{watchdog_timer_nmi, irq_req, irq_en} <= 3'(k);
			instr_end <= 1'h1;
			@(posedge core_clk) {watchdog_timer_nmi, instr_end} <= 2'h0;
			@(negedge core_clk);
			chk(nmi_take, 1'(k >> 2), "nmi");
			chk(irq_take, exp_irq(3'(k)), "irq");
		end
		@(posedge core_clk) {nmi_go, irq_req, irq_en} <= 3'h6;
		@(posedge core_clk) nmi_go <= 1'h0;
		for (int i = 0; i < 7; i++) begin
			step();
			chk(nmi_take, 1'h0, "early nmi");
		end
		@(posedge core_clk) instr_end <= 1'h1;
		@(posedge core_clk) instr_end <= 1'h0;
		@(negedge core_clk);
		chk(nmi_take, 1'h1, "pin nmi");
		end_of_test();
	end
endmodule : test_cbc_ctrl
